/* File: common/vpir_pkg.sv */
// Shared constants and types of the vectored priority interrupt router
package vpir_pkg;
    localparam int NUM_REQ = 56;
    localparam int PRIO_W = 4;
    localparam int IDX_W = 6;
    localparam int ADDR_W = 12;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_RAW_LO = 12'h000;
    localparam logic [11:0] OFS_RAW_HI = 12'h004;
    localparam logic [11:0] OFS_THR_FAST = 12'h010;
    localparam logic [11:0] OFS_THR_STD = 12'h014;
    localparam logic [11:0] OFS_VEC_FAST = 12'h020;
    localparam logic [11:0] OFS_VEC_STD = 12'h024;
    localparam logic [11:0] OFS_EVT_STS = 12'h030;
    localparam logic [11:0] OFS_EVT_MSK = 12'h034;
    localparam logic [11:0] OFS_CFG_BASE = 12'h100;
    // Field positions of a per-request config word
    localparam int CFG_PRIO_LSB = 0;
    localparam int CFG_TGT_BIT = 8;
    localparam int CFG_POL_BIT = 16;
    localparam int CFG_SWR_BIT = 24;
    // Field positions of a vector word
    localparam int VEC_PRIO_LSB = 8;
    localparam int VEC_VALID_BIT = 31;
    // Event bits
    localparam int EVT_FAST_BIT = 0;
    localparam int EVT_STD_BIT = 1;
    // Reset values
    localparam logic [3:0] PRIO_RST = 4'h0;
    localparam logic [3:0] THR_RST = 4'h0;
    localparam logic [1:0] MSK_RST = 2'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    // Bus slave states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESP = 2'b01
    } vpir_apb_st_t;
endpackage

/* File: common/vpir_arb_if.sv */
// Connection between the router core and one priority arbiter
`timescale 1ns/1ns
interface vpir_arb_if #(
    parameter int N = 56
);
    logic [N-1:0] req;     // Active requests routed to this target
    logic [4*N-1:0] prio;  // Priorities, four bits per request
    logic [3:0] thr;       // Target threshold
    logic valid;           // A request beats the threshold
    logic [5:0] idx;       // Winning request index
    logic [3:0] win;       // Winning priority
    modport src (output req, output prio, output thr, input valid, input idx, input win);
    modport arb (input req, input prio, input thr, output valid, output idx, output win);
endinterface

/* File: core/vpir_sync.sv */
// Two-stage synchroniser, one chain per bit
`timescale 1ns/1ns
module vpir_sync #(
    parameter int W = 56
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_q; // First stage, read only by the second
            logic sync_q; // Second stage
            // Two flops per bit
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= d_in[g];
                    sync_q <= meta_q;
                end
            end
            assign q_out[g] = sync_q;
        end
    endgenerate
endmodule

/* File: core/vpir_arb.sv */
// Highest-priority search over all requests of one target
`timescale 1ns/1ns
module vpir_arb #(
    parameter int N = 56
) (
    vpir_arb_if.arb a
);
    ////////////////////////////////////////////////////////////////////////
    // Elaboration check: the index field holds at most 64 requests
    if (N < 1 || N > 64) begin : g_bad_n
        $error("vpir_arb: N must be 1..64");
    end

    // Strict compare keeps the lowest index on equal priority
    always_comb begin
        logic [3:0] p;
        logic [3:0] best;
        logic [5:0] bi;
        p = 4'h0;
        best = 4'h0;
        bi = 6'h00;
        for (int i = 0; i < N; i++) begin
            p = a.prio[4*i +: 4];
            if (a.req[i] && (p > a.thr) && (p > best)) begin
                best = p;
                bi = 6'(i);
            end
        end
        a.valid = (best != 4'h0);
        a.win = best;
        a.idx = bi;
    end
endmodule

/* File: core/vpir_top.sv */
// Vectored priority interrupt router with APB register access
`timescale 1ns/1ns
// Functional notes
// - Requests are levels, per-input polarity select
// - 56 inputs, each with software request
// - Raw request state readable before masking
// - Per-input programmable priority, levels 1..15
// - Target 0 fast line, 1 standard
// - Per-target threshold compare masks requests
// - Priority 0 never interrupts
// - Level 15 highest, level 1 lowest
// - Vector names the winning request
// - Higher priority preempts lower via threshold
// - Everything runs on the controller clock
module vpir_top #(
    parameter int N = vpir_pkg::NUM_REQ
) (
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    input wire logic [N-1:0] IRQ_REQ_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic FAST_INT_OUT,
    output logic STD_INT_OUT,
    output logic [5:0] FAST_VEC_OUT,
    output logic [5:0] STD_VEC_OUT,
    output logic INT_OUT
);
    ////////////////////////////////////////////////////////////////////////
    // Parameter check
    if (N < 1 || N > 64) begin : g_bad_n
        $error("vpir_top: N must be 1..64");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [N-1:0] req_sync;         // Synchronised request pins
    logic [N-1:0] pol_q;            // One selects active-low input
    logic [N-1:0] swr_q;            // Software requests
    logic [N-1:0] tgt_q;            // Zero fast, one standard
    logic [3:0] prio_q [N];         // Priority per request
    logic [4*N-1:0] prio_flat;      // Flattened priorities
    logic [N-1:0] req_raw;          // Request state before masking
    logic [63:0] raw_wide;          // Raw state padded to two words
    logic [3:0] thr_q [2];          // Thresholds, fast then standard
    logic [1:0] sts_q;              // Sticky event bits
    logic [1:0] msk_q;              // Event mask
    logic [1:0] line_q;             // Registered target lines
    logic [5:0] vec_q [2];          // Registered vectors
    logic [3:0] vprio_q [2];        // Priority of registered winners
    vpir_pkg::vpir_apb_st_t st_q;   // Bus slave state
    vpir_pkg::vpir_apb_st_t st_d;   // Next bus slave state
    logic [31:0] rdata_q;           // Read data register
    logic [31:0] rd_d;              // Read mux
    logic err_q;                    // Slave error register
    logic rdy_q;                    // Ready pulse register
    logic hit;                      // Address is mapped
    logic cfg_hit;                  // Address is a config word
    logic [5:0] cfg_idx;            // Config word index
    logic wr_go;                    // Write commits this edge
    logic beats_fast;               // Some fast request beats the winner
    logic beats_std;                // Some standard request beats the winner

    vpir_arb_if #(.N(N)) fast_if ();
    vpir_arb_if #(.N(N)) std_if ();

    ////////////////////////////////////////////////////////////////////////
    // Request path
    vpir_sync #(.W(N)) u_sync (
        .clk_in(REF_CLK_IN),
        .rst_n_in(NRST_IN),
        .d_in(IRQ_REQ_IN),
        .q_out(req_sync)
    );

    // Polarity applied, software request merged
    assign req_raw = (req_sync ^ pol_q) | swr_q;
    assign raw_wide = 64'(req_raw);

    // Flatten priorities for the arbiters
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_flat
            assign prio_flat[4*g +: 4] = prio_q[g];
        end
    endgenerate

    // Route by target threshold per target
    assign fast_if.req = req_raw & ~tgt_q;
    assign fast_if.prio = prio_flat;
    assign fast_if.thr = thr_q[0];
    assign std_if.req = req_raw & tgt_q;
    assign std_if.prio = prio_flat;
    assign std_if.thr = thr_q[1];

    vpir_arb #(.N(N)) u_arb_fast (
        .a(fast_if)
    );
    vpir_arb #(.N(N)) u_arb_std (
        .a(std_if)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign cfg_idx = PADDR_IN[7:2];
    assign cfg_hit = (PADDR_IN[11:8] == 4'h1) && (PADDR_IN[1:0] == 2'h0)
                     && (int'(cfg_idx) < N);
    always_comb begin
        hit = cfg_hit;
        case (PADDR_IN)
            vpir_pkg::OFS_RAW_LO,
            vpir_pkg::OFS_RAW_HI,
            vpir_pkg::OFS_THR_FAST,
            vpir_pkg::OFS_THR_STD,
            vpir_pkg::OFS_VEC_FAST,
            vpir_pkg::OFS_VEC_STD,
            vpir_pkg::OFS_EVT_STS,
            vpir_pkg::OFS_EVT_MSK: hit = 1'b1;
            default: hit = cfg_hit;
        endcase
    end

    // Write commits at the edge where the ready answer is sampled
    assign wr_go = (st_q == vpir_pkg::ST_RESP) && PSEL_IN && PENABLE_IN
                   && PWRITE_IN && !err_q;

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rd_d = vpir_pkg::RDATA_RST;
        if (cfg_hit) begin
            rd_d[vpir_pkg::CFG_PRIO_LSB +: 4] = prio_q[cfg_idx];
            rd_d[vpir_pkg::CFG_TGT_BIT] = tgt_q[cfg_idx];
            rd_d[vpir_pkg::CFG_POL_BIT] = pol_q[cfg_idx];
            rd_d[vpir_pkg::CFG_SWR_BIT] = swr_q[cfg_idx];
        end else begin
            case (PADDR_IN)
                // Unmasked request state
                vpir_pkg::OFS_RAW_LO: rd_d = raw_wide[31:0];
                vpir_pkg::OFS_RAW_HI: rd_d = raw_wide[63:32];
                vpir_pkg::OFS_THR_FAST: rd_d[3:0] = thr_q[0];
                vpir_pkg::OFS_THR_STD: rd_d[3:0] = thr_q[1];
                // Vectors
                vpir_pkg::OFS_VEC_FAST: begin
                    rd_d[5:0] = vec_q[0];
                    rd_d[vpir_pkg::VEC_PRIO_LSB +: 4] = vprio_q[0];
                    rd_d[vpir_pkg::VEC_VALID_BIT] = line_q[0];
                end
                vpir_pkg::OFS_VEC_STD: begin
                    rd_d[5:0] = vec_q[1];
                    rd_d[vpir_pkg::VEC_PRIO_LSB +: 4] = vprio_q[1];
                    rd_d[vpir_pkg::VEC_VALID_BIT] = line_q[1];
                end
                vpir_pkg::OFS_EVT_STS: rd_d[1:0] = sts_q;
                vpir_pkg::OFS_EVT_MSK: rd_d[1:0] = msk_q;
                default: rd_d = vpir_pkg::RDATA_RST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave state, one wait state then ready
    always_comb begin
        st_d = st_q;
        case (st_q)
            vpir_pkg::ST_IDLE: begin
                if (PSEL_IN && PENABLE_IN) begin
                    st_d = vpir_pkg::ST_RESP;
                end
            end
            vpir_pkg::ST_RESP: st_d = vpir_pkg::ST_IDLE;
            default: st_d = vpir_pkg::ST_IDLE;
        endcase
    end

    // All state on the controller clock
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            st_q <= vpir_pkg::ST_IDLE;
            rdata_q <= vpir_pkg::RDATA_RST;
            err_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            // Ready straight from a flop, high while in the answer state
            rdy_q <= (st_d == vpir_pkg::ST_RESP);
            if (st_q == vpir_pkg::ST_IDLE && PSEL_IN && PENABLE_IN) begin
                // Capture answer; unmapped reads zero with error
                rdata_q <= PWRITE_IN ? vpir_pkg::RDATA_RST : rd_d;
                err_q <= !hit;
            end else begin
                rdata_q <= vpir_pkg::RDATA_RST;
                err_q <= 1'b0;
            end
        end
    end

    assign PREADY_OUT = rdy_q;
    assign PRDATA_OUT = rdata_q;
    assign PSLVERR_OUT = err_q;

    ////////////////////////////////////////////////////////////////////////
    // Per-request configuration
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pol_q <= '0;
            swr_q <= '0;
            tgt_q <= '0;
            for (int i = 0; i < N; i++) begin
                prio_q[i] <= vpir_pkg::PRIO_RST;
            end
        end else if (wr_go && cfg_hit) begin
            // Priority 0 stored as masked
            prio_q[cfg_idx] <= PWDATA_IN[vpir_pkg::CFG_PRIO_LSB +: 4];
            tgt_q[cfg_idx] <= PWDATA_IN[vpir_pkg::CFG_TGT_BIT];
            pol_q[cfg_idx] <= PWDATA_IN[vpir_pkg::CFG_POL_BIT];
            swr_q[cfg_idx] <= PWDATA_IN[vpir_pkg::CFG_SWR_BIT];
        end
    end

    // Thresholds; raising one to the active level allows nesting
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            thr_q[0] <= vpir_pkg::THR_RST;
            thr_q[1] <= vpir_pkg::THR_RST;
        end else if (wr_go && PADDR_IN == vpir_pkg::OFS_THR_FAST) begin
            thr_q[0] <= PWDATA_IN[3:0];
        end else if (wr_go && PADDR_IN == vpir_pkg::OFS_THR_STD) begin
            thr_q[1] <= PWDATA_IN[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Target lines and vectors, registered
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            line_q <= 2'h0;
            vec_q[0] <= 6'h00;
            vec_q[1] <= 6'h00;
            vprio_q[0] <= 4'h0;
            vprio_q[1] <= 4'h0;
        end else begin
            line_q <= {std_if.valid, fast_if.valid};
            vec_q[0] <= fast_if.idx;
            vec_q[1] <= std_if.idx;
            vprio_q[0] <= fast_if.win;
            vprio_q[1] <= std_if.win;
        end
    end

    assign FAST_INT_OUT = line_q[0];
    assign STD_INT_OUT = line_q[1];
    assign FAST_VEC_OUT = vec_q[0];
    assign STD_VEC_OUT = vec_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Event status and mask; a new assertion wins over a clear
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            sts_q <= 2'h0;
        end else begin
            sts_q <= (wr_go && PADDR_IN == vpir_pkg::OFS_EVT_STS)
                     ? (sts_q & ~PWDATA_IN[1:0]) : sts_q;
            if (fast_if.valid && !line_q[0]) begin
                sts_q[vpir_pkg::EVT_FAST_BIT] <= 1'b1;
            end
            if (std_if.valid && !line_q[1]) begin
                sts_q[vpir_pkg::EVT_STD_BIT] <= 1'b1;
            end
        end
    end

    // Mask register
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            msk_q <= vpir_pkg::MSK_RST;
        end else if (wr_go && PADDR_IN == vpir_pkg::OFS_EVT_MSK) begin
            msk_q <= PWDATA_IN[1:0];
        end
    end

    // Level interrupt output
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            INT_OUT <= 1'b0;
        end else begin
            INT_OUT <= |(sts_q & msk_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checking helpers: no competitor outranks a winner
    always_comb begin
        beats_fast = 1'b0;
        beats_std = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (fast_if.req[i] && prio_q[i] > fast_if.win && prio_q[i] > thr_q[0]) begin
                beats_fast = 1'b1;
            end
            if (std_if.req[i] && prio_q[i] > std_if.win && prio_q[i] > thr_q[1]) begin
                beats_std = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sw_req_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        ((req_raw & swr_q) == swr_q))
        else $error("software request not visible");
    pol_level_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (|(pol_q & ~req_sync)) |-> ((req_raw & pol_q & ~req_sync) == (pol_q & ~req_sync)))
        else $error("active-low input not seen active");
    raw_read_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (PREADY_OUT && !PWRITE_IN && PADDR_IN == vpir_pkg::OFS_RAW_LO)
        |-> (PRDATA_OUT == $past(raw_wide[31:0])))
        else $error("raw request read mismatch");
    prio_wr_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (wr_go && cfg_hit) |=> (prio_q[$past(cfg_idx)] == $past(PWDATA_IN[3:0])))
        else $error("priority write lost");
    fast_route_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        fast_if.valid |-> (!tgt_q[fast_if.idx] && req_raw[fast_if.idx]))
        else $error("fast line served a standard request");
    thr_mask_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        std_if.valid |-> (std_if.win > thr_q[1]))
        else $error("standard winner not above threshold");
    prio_zero_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        FAST_INT_OUT |-> ($past(prio_q[fast_if.idx]) != 4'h0 && vprio_q[0] != 4'h0))
        else $error("priority zero raised an interrupt");
    best_win_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (fast_if.valid || std_if.valid) |-> (!beats_fast && !beats_std))
        else $error("lower priority won arbitration");
    vec_out_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        STD_INT_OUT |-> $past(std_if.req[std_if.idx]) && (vprio_q[1] > $past(thr_q[1])))
        else $error("vector names an inactive request");
    line_gate_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        FAST_INT_OUT |-> $past(fast_if.req[fast_if.idx]) && (vprio_q[0] > $past(thr_q[0])))
        else $error("fast line without qualifying request");
    int_level_a: assert property (@(posedge REF_CLK_IN) disable iff (!NRST_IN)
        (sts_q[0] && msk_q[0]) |=> INT_OUT)
        else $error("unmasked event did not raise interrupt");
endmodule

/* File: verif/vpir_core_model.sv */
// Model of the processor core inputs that watch the two interrupt lines
`timescale 1ns/1ns
module vpir_core_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic fast_in,
    input wire logic std_in,
    input wire logic [5:0] fast_vec_in,
    input wire logic [5:0] std_vec_in,
    output logic [5:0] fast_take_out,
    output logic [5:0] std_take_out
);
    logic fast_q; // Fast line seen one edge ago
    logic std_q; // Standard line seen one edge ago

    ////////////////////////////////////////////////////////////////////////
    // Core takes the vector on each entry into service, at a line rising
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fast_q <= 1'b0;
            std_q <= 1'b0;
            fast_take_out <= 6'h00;
            std_take_out <= 6'h00;
        end else begin
            fast_q <= fast_in;
            std_q <= std_in;
            // Entry into fast service
            if (fast_in && !fast_q) begin
                fast_take_out <= fast_vec_in;
            end
            // Entry into standard service
            if (std_in && !std_q) begin
                std_take_out <= std_vec_in;
            end
        end
    end
endmodule

/* File: verif/vpir_top_tb.sv */
// Self-checking bench of the interrupt router, driven over APB
`timescale 1ns/1ns
module vpir_top_tb;
    localparam int N = vpir_pkg::NUM_REQ;
    localparam int MAX_CYC = 4000; // Ceiling of the whole run
    logic clk = 1'b0; // Controller clock
    logic rst_n = 1'b0; // Reset, active low
    logic [N-1:0] irq = '0; // Request pins
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, fast_int, std_int, int_line;
    logic [5:0] fast_vec, std_vec, fast_take, std_take;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] rv; // Read data of a raw access
    logic re; // Error flag of a raw access

    always #25 clk = ~clk;

    vpir_top #(.N(N)) i_dut (.REF_CLK_IN(clk), .NRST_IN(rst_n), .IRQ_REQ_IN(irq),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .FAST_INT_OUT(fast_int), .STD_INT_OUT(std_int),
        .FAST_VEC_OUT(fast_vec), .STD_VEC_OUT(std_vec), .INT_OUT(int_line));

    vpir_core_model i_core (.clk_in(clk), .rst_n_in(rst_n), .fast_in(fast_int),
        .std_in(std_int), .fast_vec_in(fast_vec), .std_vec_in(std_vec),
        .fast_take_out(fast_take), .std_take_out(std_take));

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == MAX_CYC) begin
            err_total++;
            conclude();
        end
    end

    // Compare one value
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; waits for the slave, releases at the sampling edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, rv, exp);
    endtask

    // Let a change reach the lines: pin path is three edges
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    // Check both lines and the vectors of active lines
    task automatic lines(input logic f, input logic s, input logic [5:0] fv, input logic [5:0] sv);
        check("fast line", {31'h0, fast_int}, {31'h0, f});
        check("std line", {31'h0, std_int}, {31'h0, s});
        if (f) check("fast vector", {26'h0, fast_vec}, {26'h0, fv});
        if (s) check("std vector", {26'h0, std_vec}, {26'h0, sv});
    endtask

    // Config word address and contents of request i
    function automatic logic [11:0] ca(input int i);
        return vpir_pkg::OFS_CFG_BASE + 12'(4 * i);
    endfunction

    function automatic logic [31:0] cw(input logic [3:0] p, input logic t, input logic pol,
        input logic sw);
        return {7'h00, sw, 7'h00, pol, 7'h00, t, 4'h0, p};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // Reset state and an unmapped address
        lines(1'b0, 1'b0, 6'h00, 6'h00);
        rd_chk("fast threshold", vpir_pkg::OFS_THR_FAST, 32'h0000_0000);
        rd_chk("event mask", vpir_pkg::OFS_EVT_MSK, 32'h0000_0000);
        rd_chk("config 0", ca(0), 32'h0000_0000);
        apb(1'b0, 12'h200, 32'h0000_0000);
        check("unmapped error", {31'h0, re}, 32'h0000_0001);
        $display("test reset done");
        // Priority 0 masks, raw state still visible
        irq[3] <= 1'b1;
        settle();
        rd_chk("raw low", vpir_pkg::OFS_RAW_LO, 32'h0000_0008);
        lines(1'b0, 1'b0, 6'h00, 6'h00);
        // Routing to fast line and threshold compare
        wr(ca(3), cw(4'h5, 1'b0, 1'b0, 1'b0));
        settle();
        lines(1'b1, 1'b0, 6'h03, 6'h00);
        rd_chk("fast vector reg", vpir_pkg::OFS_VEC_FAST, 32'h8000_0503);
        wr(vpir_pkg::OFS_THR_FAST, 32'h0000_0005);
        settle();
        lines(1'b0, 1'b0, 6'h00, 6'h00);
        wr(vpir_pkg::OFS_THR_FAST, 32'h0000_0004);
        settle();
        lines(1'b1, 1'b0, 6'h03, 6'h00);
        wr(vpir_pkg::OFS_THR_FAST, 32'h0000_0000);
        $display("test routing done");
        // Software requests, ordering and ties
        wr(ca(40), cw(4'h1, 1'b0, 1'b0, 1'b1));
        settle();
        lines(1'b1, 1'b0, 6'h03, 6'h00);
        rd_chk("raw high", vpir_pkg::OFS_RAW_HI, 32'h0000_0100);
        wr(ca(40), cw(4'hf, 1'b0, 1'b0, 1'b1));
        wr(ca(41), cw(4'hf, 1'b0, 1'b0, 1'b1));
        settle();
        lines(1'b1, 1'b0, 6'h28, 6'h00);
        wr(ca(41), cw(4'hf, 1'b1, 1'b0, 1'b1));
        settle();
        lines(1'b1, 1'b1, 6'h28, 6'h29);
        check("core took std", {26'h0, std_take}, 32'h0000_0029);
        wr(vpir_pkg::OFS_THR_STD, 32'h0000_000f);
        settle();
        lines(1'b1, 1'b0, 6'h28, 6'h00);
        wr(vpir_pkg::OFS_THR_STD, 32'h0000_0000);
        $display("test ordering done");
        // Polarity: low pin is active when inverted
        wr(ca(10), cw(4'h2, 1'b1, 1'b1, 1'b0));
        wr(ca(41), cw(4'h0, 1'b1, 1'b0, 1'b1));
        settle();
        rd_chk("raw low inverted", vpir_pkg::OFS_RAW_LO, 32'h0000_0408);
        lines(1'b1, 1'b1, 6'h28, 6'h0a);
        irq[10] <= 1'b1;
        settle();
        lines(1'b1, 1'b0, 6'h28, 6'h00);
        $display("test polarity done");
        // Nested service: threshold raised to priority in service
        wr(ca(40), cw(4'hf, 1'b0, 1'b0, 1'b0));
        wr(vpir_pkg::OFS_THR_FAST, 32'h0000_0005);
        settle();
        lines(1'b0, 1'b0, 6'h00, 6'h00);
        wr(ca(40), cw(4'hf, 1'b0, 1'b0, 1'b1));
        settle();
        lines(1'b1, 1'b0, 6'h28, 6'h00);
        check("core took", {26'h0, fast_take}, 32'h0000_0028);
        $display("test nesting done");
        // Events: sticky status, mask, clear by writing one
        rd_chk("event status", vpir_pkg::OFS_EVT_STS, 32'h0000_0003);
        check("int masked", {31'h0, int_line}, 32'h0000_0000);
        wr(vpir_pkg::OFS_EVT_MSK, 32'h0000_0001);
        settle();
        check("int raised", {31'h0, int_line}, 32'h0000_0001);
        wr(vpir_pkg::OFS_EVT_STS, 32'h0000_0003);
        settle();
        check("int cleared", {31'h0, int_line}, 32'h0000_0000);
        rd_chk("status cleared", vpir_pkg::OFS_EVT_STS, 32'h0000_0000);
        wr(vpir_pkg::OFS_THR_FAST, 32'h0000_000f);
        settle();
        wr(vpir_pkg::OFS_THR_FAST, 32'h0000_0000);
        settle();
        check("int again", {31'h0, int_line}, 32'h0000_0001);
        $display("test events done");
        conclude();
    end
endmodule
